// ### src/dcs_top.sv
// Notes on behaviour
// - Codes 0-12 fixed rate, 13 timer
// - Receiver A: 14 external 16x, 15 external 1x, from pin four
// - Transmitter A external clock from pin three
// - Receiver B external clock from pin six
// - Transmitter B external clock from pin five
// - Fixed rates divided from reference clock
// - Several commands per write, none conflicting
// - Misc field: nothing, or pointer reset
// - Code 2 resets and disables receiver
// - Code 3 resets transmitter
// - Code 4 clears four error flags
// - Code 5 clears break-change flag
// - Code 6 starts break after queue
// - Start break needs enabled transmitter
// - Code 7 ends break, one mark bit
// - Disable clears flags, queued characters finish
// - Enable starts transmitter, sets ready
// - Receiver disable immediate, multidrop keeps running
// - Receiver enable hunts start unless wake-up
// - Enable with disable means disable
// - Overrun on full buffer, held character
// - Read of speed word toggles rate set
// - Aux bit picks one of two sets
`timescale 1ns/1ps
`default_nettype none
module dcs_top
  import dcs_pkg::*;
(
  input  wire logic              clk,             // System clock
  input  wire logic              sys_rst,         // Sync reset, high
  input  wire logic [5:0]        address,         // Byte address
  input  wire logic              read,            // Read request
  input  wire logic              write,           // Write request
  input  wire logic [3:0]        byteenable,      // Byte lanes
  input  wire logic [31:0]       writedata,       // Write data
  output var  logic [31:0]       readdata,        // Read data
  output var  logic              waitrequest,     // Stall
  input  wire logic              timerTick,       // Counter/timer 16x tick
  input  wire logic              inputPinThree,   // External clock pin
  input  wire logic              inputPinFour,    // External clock pin
  input  wire logic              inputPinFive,    // External clock pin
  input  wire logic              inputPinSix,     // External clock pin
  input  wire dcs_evt_t [1:0]    chanEvt,         // Channel events
  output var  dcs_ctrl_t [1:0]   chanCtrl,        // Channel controls
  output var  logic [3:0]        clkTick,         // RxA,TxA,RxB,TxB ticks
  output var  logic [3:0]        clkIs1x          // Tick is 1x rate
);

  ////////////////////////////////////////////////////////////////////////
  // Fixed divisors of the 16x reference, per code and rate set
  function automatic logic [DIV_W-1:0] rateDiv(input logic [3:0] code, input logic setSel);
    logic [DIV_W-1:0] d;
    d = 13'h0001;
    unique case (code)
      4'h0: d = setSel ? 13'h0C00 : 13'h1200;
      4'h1: d = 13'h082F;
      4'h2: d = 13'h06B1;
      4'h3: d = setSel ? 13'h0600 : 13'h0480;
      4'h4: d = 13'h0300;
      4'h5: d = 13'h0180;
      4'h6: d = 13'h00C0;
      4'h7: d = setSel ? 13'h0073 : 13'h00DC;
      4'h8: d = 13'h0060;
      4'h9: d = 13'h0030;
      4'hA: d = setSel ? 13'h0080 : 13'h0020;
      4'hB: d = 13'h0018;
      4'hC: d = setSel ? 13'h000C : 13'h0006;
      default: d = 13'h0001;
    endcase
    return d;
  endfunction

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, then a one-cycle answer
  logic        waitQ;
  logic        rdDone;
  logic        wrDone;
  logic [7:0]  cselQ [2];
  logic [7:0]  auxQ;
  logic        hsModeQ;
  logic [1:0]  cmdWr;
  logic [7:0]  cmdByte;

  assign rdDone  = read && !waitQ;
  assign wrDone  = write && !waitQ && byteenable[0];
  assign cmdByte = writedata[7:0];
  assign cmdWr   = {wrDone && address == OFS_CMD_B, wrDone && address == OFS_CMD_A};
  assign waitrequest = waitQ;

  // Stall the first cycle of every request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      waitQ <= 1'b1;
    end else begin
      waitQ <= !((read || write) && waitQ);
    end
  end

  // Clock select and aux words; command bit seven is simply ignored
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cselQ[0] <= CSEL_RESET;
      cselQ[1] <= CSEL_RESET;
      auxQ     <= AUX_RESET;
    end else if (wrDone) begin
      if (address == OFS_CSEL_A) cselQ[0] <= writedata[7:0];
      if (address == OFS_CSEL_B) cselQ[1] <= writedata[7:0];
      if (address == OFS_AUX)    auxQ     <= writedata[7:0];
    end
  end

  // Each completed read of the speed word flips the rate set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hsModeQ <= 1'b0;
    end else if (rdDone && address == OFS_SPEED) begin
      hsModeQ <= !hsModeQ;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-channel state
  logic       rxEnQ     [2];
  logic       rxRunQ    [2];
  logic       rxHuntQ   [2];
  logic       rxRstQ    [2];
  logic       txEnQ     [2];
  logic       txRunQ    [2];
  logic       txRstQ    [2];
  logic       mrPtrQ    [2];
  logic       readyQ    [2];
  logic       emptyQ    [2];
  logic [3:0] errQ      [2];
  logic       brkChgQ   [2];
  dcs_brk_t   brkQ      [2];
  logic       markCntQ  [2];
  logic       serOutQ   [2];
  logic       txHoldQ   [2];
  logic [3:0] bitCntQ   [2];
  logic [1:0] bitTick;
  logic [2:0] misc      [2];
  logic       rxEnC     [2];
  logic       rxDisC    [2];
  logic       txEnC     [2];
  logic       txDisC    [2];

  // Field decode; reserved top bit is never looked at
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      misc[c]   = cmdWr[c] ? cmdByte[CMD_MISC_LSB +: 3] : MC_NONE;
      rxEnC[c]  = cmdWr[c] && cmdByte[CMD_RX_EN];
      rxDisC[c] = cmdWr[c] && cmdByte[CMD_RX_DIS];
      txEnC[c]  = cmdWr[c] && cmdByte[CMD_TX_EN];
      txDisC[c] = cmdWr[c] && cmdByte[CMD_TX_DIS];
    end
  end

  // Status word: channel A low byte, channel B next byte
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitQ) begin
      readdata <= 32'h0000_0000;
      if (address == OFS_STAT) begin
        for (int c = 0; c < 2; c++) begin
          readdata[8*c +: 8] <= {errQ[c], emptyQ[c], readyQ[c], txEnQ[c], rxEnQ[c]};
          readdata[16 + c]   <= brkChgQ[c];
        end
        readdata[24] <= hsModeQ;
        readdata[25] <= auxQ[AUX_SET_BIT];
      end
    end
  end

  // Receiver enable; disable wins, multidrop keeps it running
  always_ff @(posedge clk) begin
    for (int c = 0; c < 2; c++) begin
      if (sys_rst) begin
        rxEnQ[c]   <= 1'b0;
        rxRunQ[c]  <= 1'b0;
        rxHuntQ[c] <= 1'b0;
        rxRstQ[c]  <= 1'b0;
        mrPtrQ[c]  <= 1'b0;
      end else begin
        rxRstQ[c]  <= misc[c] == MC_RXRST;
        mrPtrQ[c]  <= misc[c] == MC_MRPTR;
        rxHuntQ[c] <= rxEnC[c] && !rxDisC[c] && misc[c] != MC_RXRST && !chanEvt[c].wakeMode;
        if (misc[c] == MC_RXRST || rxDisC[c]) begin
          rxEnQ[c]  <= 1'b0;
          rxRunQ[c] <= chanEvt[c].multidrop && misc[c] != MC_RXRST;
        end else if (rxEnC[c]) begin
          rxEnQ[c]  <= 1'b1;
          rxRunQ[c] <= 1'b1;
        end else begin
          rxRunQ[c] <= rxEnQ[c] || chanEvt[c].multidrop;
        end
      end
    end
  end

  // Error flags: an arriving event beats a clear in the same cycle
  always_ff @(posedge clk) begin
    for (int c = 0; c < 2; c++) begin
      if (sys_rst) begin
        errQ[c]    <= 4'h0;
        brkChgQ[c] <= 1'b0;
      end else begin
        errQ[c] <= {chanEvt[c].brkSet, chanEvt[c].frameErr, chanEvt[c].parErr,
                    chanEvt[c].rxChar && chanEvt[c].fifoFull && chanEvt[c].shiftHeld}
                 | (errQ[c] & {4{misc[c] != MC_ERRCLR && misc[c] != MC_RXRST}});
        brkChgQ[c] <= chanEvt[c].brkChange || (brkChgQ[c] && misc[c] != MC_BRKCLR);
      end
    end
  end

  // Transmitter enable and its ready/empty flags
  always_ff @(posedge clk) begin
    for (int c = 0; c < 2; c++) begin
      if (sys_rst) begin
        txEnQ[c]  <= 1'b0;
        txRunQ[c] <= 1'b0;
        txRstQ[c] <= 1'b0;
        readyQ[c] <= 1'b0;
        emptyQ[c] <= 1'b0;
      end else begin
        txRstQ[c] <= misc[c] == MC_TXRST;
        if (misc[c] == MC_TXRST) begin
          txEnQ[c]  <= 1'b0;
          txRunQ[c] <= 1'b0;
          readyQ[c] <= 1'b0;
          emptyQ[c] <= 1'b0;
        end else if (txDisC[c]) begin
          txEnQ[c]  <= 1'b0;
          txRunQ[c] <= chanEvt[c].txBusy;
          readyQ[c] <= 1'b0;
          emptyQ[c] <= 1'b0;
        end else if (txEnC[c]) begin
          txEnQ[c]  <= 1'b1;
          txRunQ[c] <= 1'b1;
          readyQ[c] <= 1'b1;
          emptyQ[c] <= 1'b1;
        end else begin
          // Queued work drains before the transmitter goes quiet
          txRunQ[c] <= txEnQ[c] || (txRunQ[c] && chanEvt[c].txBusy);
          if (txEnQ[c] && chanEvt[c].holdToShift) begin
            readyQ[c] <= 1'b1;
          end else if (chanEvt[c].holdLoad) begin
            readyQ[c] <= 1'b0;
          end
          if (chanEvt[c].holdLoad) begin
            emptyQ[c] <= 1'b0;
          end else if (txEnQ[c] && readyQ[c] && !chanEvt[c].txBusy) begin
            emptyQ[c] <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit-time tick of each transmitter from its 16x or 1x tick
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      bitTick[c] = clkTick[2*c+1] && (clkIs1x[2*c+1] || bitCntQ[c] == 4'hF);
    end
  end

  always_ff @(posedge clk) begin
    for (int c = 0; c < 2; c++) begin
      if (sys_rst) begin
        bitCntQ[c] <= 4'h0;
      end else if (clkTick[2*c+1]) begin
        bitCntQ[c] <= bitCntQ[c] + 4'h1;
      end
    end
  end

  // Break sequencer; break starts on a bit edge, but code 7 ends it at once, even mid-bit
  always_ff @(posedge clk) begin
    for (int c = 0; c < 2; c++) begin
      if (sys_rst || misc[c] == MC_TXRST) begin
        brkQ[c]     <= BK_IDLE;
        markCntQ[c] <= 1'b0;
      end else begin
        unique case (brkQ[c])
          BK_IDLE: if (misc[c] == MC_BRKON && txEnQ[c]) begin
            brkQ[c] <= BK_WAIT;
          end
          BK_WAIT: if (misc[c] == MC_BRKOFF) begin
            brkQ[c] <= BK_IDLE;
          end else if (bitTick[c] && !chanEvt[c].txBusy) begin
            brkQ[c] <= BK_ON;
          end
          BK_ON: if (misc[c] == MC_BRKOFF) begin
            brkQ[c]     <= BK_MARK;
            markCntQ[c] <= 1'b0;
          end
          BK_MARK: if (bitTick[c]) begin
            // Two edges guarantee a full bit of mark
            markCntQ[c] <= 1'b1;
            if (markCntQ[c]) brkQ[c] <= BK_IDLE;
          end
        endcase
      end
    end
  end

  // Serial line: spacing in break, marking after it; hold flag registered alongside so both move together
  always_ff @(posedge clk) begin
    for (int c = 0; c < 2; c++) begin
      if (sys_rst) begin
        serOutQ[c] <= 1'b1;
        txHoldQ[c] <= 1'b0;
      end else begin
        serOutQ[c] <= (brkQ[c] == BK_ON) ? 1'b0 : (brkQ[c] == BK_MARK) ? 1'b1 : chanEvt[c].txLine;
        txHoldQ[c] <= brkQ[c] == BK_ON || brkQ[c] == BK_MARK;
      end
    end
  end

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      chanCtrl[c].rxRun      = rxRunQ[c];
      chanCtrl[c].rxHunt     = rxHuntQ[c];
      chanCtrl[c].rxReset    = rxRstQ[c];
      chanCtrl[c].txRun      = txRunQ[c];
      chanCtrl[c].txReset    = txRstQ[c];
      chanCtrl[c].mrPtrReset = mrPtrQ[c];
      chanCtrl[c].txHold     = txHoldQ[c];
      chanCtrl[c].serialOut  = serOutQ[c];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reference tick: fractional accumulator, so rates track REF_HZ exactly
  logic [23:0] refAccQ;
  logic        refTick;
  logic [24:0] refSum;
  assign refSum  = {1'b0, refAccQ} + 25'(REF_HZ);
  assign refTick = refSum >= 25'(CLK_HZ);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refAccQ <= 24'h000000;
    end else begin
      refAccQ <= refTick ? 24'(refSum - 25'(CLK_HZ)) : refSum[23:0];
    end
  end

  // Clock selectors: RxA, TxA, RxB, TxB
  logic [3:0]       pinNow;
  logic [3:0]       pinQ;
  logic [3:0]       pinRise;
  logic [3:0]       selCode [4];
  logic [DIV_W-1:0] divCntQ [4];
  logic [DIV_W-1:0] divLim  [4];

  assign pinNow  = {inputPinFive, inputPinSix, inputPinThree, inputPinFour};
  assign pinRise = pinNow & ~pinQ;

  always_comb begin
    for (int s = 0; s < 4; s++) begin
      selCode[s] = cselQ[s/2][(s % 2 == 0) ? 4 : 0 +: 4];
      divLim[s]  = hsModeQ ? (rateDiv(selCode[s], auxQ[AUX_SET_BIT]) >> 1)
                           : rateDiv(selCode[s], auxQ[AUX_SET_BIT]);
      if (divLim[s] == 13'h0000) divLim[s] = 13'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinQ <= 4'h0;
    end else begin
      pinQ <= pinNow;
    end
  end

  always_ff @(posedge clk) begin
    for (int s = 0; s < 4; s++) begin
      if (sys_rst) begin
        divCntQ[s] <= 13'h0000;
        clkTick[s] <= 1'b0;
        clkIs1x[s] <= 1'b0;
      end else begin
        clkIs1x[s] <= selCode[s] == CODE_EXT1;
        clkTick[s] <= 1'b0;
        if (selCode[s] == CODE_TIMER) begin
          clkTick[s] <= timerTick;
        end else if (selCode[s] >= CODE_EXT16) begin
          clkTick[s] <= pinRise[s];
        end else if (refTick) begin
          if (divCntQ[s] >= divLim[s] - 13'h0001) begin
            divCntQ[s] <= 13'h0000;
            clkTick[s] <= 1'b1;
          end else begin
            divCntQ[s] <= divCntQ[s] + 13'h0001;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_one_wait;
    (read || write) && !waitrequest |-> $past(waitrequest);
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("answer without wait state");

  property p_timer_sel;
    cselQ[0][7:4] == CODE_TIMER && timerTick |=> clkTick[0];
  endproperty
  a_timer_sel: assert property (p_timer_sel) else $error("timer tick not passed");

  property p_rx_1x;
    cselQ[0][7:4] == CODE_EXT1 |=> clkIs1x[0];
  endproperty
  a_rx_1x: assert property (p_rx_1x) else $error("1x flag missing");

  property p_pin3;
    cselQ[0][3:0] >= CODE_EXT16 && inputPinThree && !pinQ[1] |=> clkTick[1];
  endproperty
  a_pin3: assert property (p_pin3) else $error("pin three edge lost");

  property p_pin6;
    cselQ[1][7:4] >= CODE_EXT16 && inputPinSix && !pinQ[2] |=> clkTick[2];
  endproperty
  a_pin6: assert property (p_pin6) else $error("pin six edge lost");

  property p_pin5;
    cselQ[1][3:0] == CODE_EXT16 && !(inputPinFive && !pinQ[3]) |=> !clkTick[3];
  endproperty
  a_pin5: assert property (p_pin5) else $error("pin five spurious tick");

  property p_brk_gate;
    misc[0] == MC_BRKON && !txEnQ[0] && brkQ[0] == BK_IDLE |=> brkQ[0] == BK_IDLE;
  endproperty
  a_brk_gate: assert property (p_brk_gate) else $error("break taken while disabled");

  property p_dis_wins;
    rxEnC[0] && rxDisC[0] |=> !rxEnQ[0] ##1 !rxEnQ[0] || rxEnC[0];
  endproperty
  a_dis_wins: assert property (p_dis_wins) else $error("enable beat disable");

  property p_tx_ready;
    txEnC[1] && !txDisC[1] && misc[1] != MC_TXRST |=> readyQ[1] && emptyQ[1] && txRunQ[1];
  endproperty
  a_tx_ready: assert property (p_tx_ready) else $error("enable did not set ready");

  property p_overrun;
    chanEvt[0].rxChar && chanEvt[0].fifoFull && chanEvt[0].shiftHeld |=> errQ[0][0];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_mark;
    brkQ[0] == BK_MARK |=> serOutQ[0];
  endproperty
  a_mark: assert property (p_mark) else $error("line not marking after break");

endmodule
`default_nettype wire

// ### pkg/dcs_pkg.sv
`default_nettype none
package dcs_pkg;
  // Clocking
  localparam int          CLK_HZ       = 10_000_000;
  localparam int          REF_HZ       = 3_686_400;
  localparam int          OVERSAMPLE   = 16;
  localparam int          DIV_W        = 13;
  // Byte offsets of the register words
  localparam logic [5:0]  OFS_CSEL_A   = 6'h04;
  localparam logic [5:0]  OFS_CMD_A    = 6'h08;
  localparam logic [5:0]  OFS_SPEED    = 6'h08;
  localparam logic [5:0]  OFS_AUX      = 6'h10;
  localparam logic [5:0]  OFS_STAT     = 6'h14;
  localparam logic [5:0]  OFS_CSEL_B   = 6'h24;
  localparam logic [5:0]  OFS_CMD_B    = 6'h28;
  // Command fields
  localparam int          CMD_RX_EN    = 0;
  localparam int          CMD_RX_DIS   = 1;
  localparam int          CMD_TX_EN    = 2;
  localparam int          CMD_TX_DIS   = 3;
  localparam int          CMD_MISC_LSB = 4;
  localparam int          AUX_SET_BIT  = 7;
  localparam logic [7:0]  CSEL_RESET   = 8'h00;
  localparam logic [7:0]  AUX_RESET    = 8'h00;
  typedef enum logic [2:0] {
    MC_NONE = 3'h0, MC_MRPTR = 3'h1, MC_RXRST = 3'h2, MC_TXRST = 3'h3,
    MC_ERRCLR = 3'h4, MC_BRKCLR = 3'h5, MC_BRKON = 3'h6, MC_BRKOFF = 3'h7
  } dcs_misc_t;
  // Clock select codes
  localparam logic [3:0]  CODE_TIMER   = 4'hD;
  localparam logic [3:0]  CODE_EXT16   = 4'hE;
  localparam logic [3:0]  CODE_EXT1    = 4'hF;
  // Break sequencer
  typedef enum logic [3:0] {
    BK_IDLE = 4'b0001, BK_WAIT = 4'b0010, BK_ON = 4'b0100, BK_MARK = 4'b1000
  } dcs_brk_t;
  // Controls toward one channel's receiver and transmitter
  typedef struct packed {
    logic rxRun;
    logic rxHunt;
    logic rxReset;
    logic txRun;
    logic txReset;
    logic mrPtrReset;
    logic txHold;
    logic serialOut;
  } dcs_ctrl_t;
  // Events from one channel's receiver and transmitter
  typedef struct packed {
    logic txBusy;
    logic txLine;
    logic holdLoad;
    logic holdToShift;
    logic rxChar;
    logic fifoFull;
    logic shiftHeld;
    logic brkSet;
    logic frameErr;
    logic parErr;
    logic brkChange;
    logic wakeMode;
    logic multidrop;
  } dcs_evt_t;
endpackage
`default_nettype wire

// ### tb/dcs_host.sv
`timescale 1ns/1ps
`default_nettype none
module dcs_host
  import dcs_pkg::*;
(
  input  wire logic        clk,         // System clock
  output var  logic [5:0]  address,     // Byte address
  output var  logic        read,        // Read request
  output var  logic        write,       // Write request
  output var  logic [3:0]  byteenable,  // Byte lanes
  output var  logic [31:0] writedata,   // Write data
  input  wire logic [31:0] readdata,    // Read data
  input  wire logic        waitrequest  // Stall
);
  // Idle bus at time zero
  initial begin
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h0;
    writedata = 32'h0;
  end
  // One transfer, held until waitrequest is sampled low; no cycle count assumed
  task automatic xfer(input logic [5:0] a, input logic rd, input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
    @(posedge clk);
    address <= a;
    read <= rd;
    write <= !rd;
    byteenable <= be;
    writedata <= ((a == OFS_CMD_A) || (a == OFS_CMD_B)) ? {24'h0, 1'b0, d[6:0]} : d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // Released data flips so a stale value never looks valid
    writedata <= ~writedata;
  endtask
endmodule
`default_nettype wire

// ### tb/dcs_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dcs_top_bench
  import dcs_pkg::*;
;
  logic            clk;
  logic            sysRst;
  logic [5:0]      address;
  logic            read;
  logic            write;
  logic [3:0]      byteenable;
  logic [31:0]     writedata;
  logic [31:0]     readdata;
  logic            waitrequest;
  logic [4:0]      pins;
  dcs_evt_t [1:0]  evt;
  dcs_ctrl_t [1:0] ctrl;
  logic [3:0]      clkTick;
  logic [3:0]      clkIs1x;
  logic [15:0]     tc [4];
  logic [7:0]      mrC, rxC, txC, huntC;
  int              error_cnt;
  int              n_tests;

  ////////////////////////////////////////////////////////////////
  // 100 ns clock, pins {timer,six,five,four,three}
  initial clk = 1'b0;
  always #50 clk = ~clk;
  dcs_top dut (.clk(clk), .sys_rst(sysRst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .timerTick(pins[4]), .inputPinThree(pins[0]), .inputPinFour(pins[1]), .inputPinFive(pins[2]),
    .inputPinSix(pins[3]), .chanEvt(evt), .chanCtrl(ctrl), .clkTick(clkTick), .clkIs1x(clkIs1x));
  dcs_host host (.clk(clk), .address(address), .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));

  // Pulse and tick tallies, so one-cycle outputs are never missed
  // Cleared in reset, so unknown outputs before the first edge never poison them
  always_ff @(posedge clk) begin
    if (sysRst) begin
      for (int i = 0; i < 4; i++) tc[i] <= 16'h0;
      {mrC, rxC, txC, huntC} <= 32'h0;
    end else begin
      for (int i = 0; i < 4; i++) tc[i] <= tc[i] + 16'(clkTick[i]);
      mrC <= mrC + 8'(ctrl[0].mrPtrReset);
      rxC <= rxC + 8'(ctrl[0].rxReset);
      txC <= txC + 8'(ctrl[0].txReset);
      huntC <= huntC + 8'(ctrl[0].rxHunt);
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [31:0] q;
    host.xfer(a, 1'b0, {24'h0, d}, 4'hF, q);
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] q);
    host.xfer(a, 1'b1, 32'h0, 4'hF, q);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkst(input string nm, input int b, input logic e);
    logic [31:0] q;
    rd(OFS_STAT, q);
    chk(nm, {31'h0, e}, {31'h0, q[b]});
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge clk);
    pins <= m;
    @(posedge clk);
    pins <= 5'h00;
    repeat (3) @(posedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] q;
    rd(OFS_STAT, q);
    chk("status after reset", 32'h0, q);
    chk("ctrl after reset", 32'h0101, {16'h0, ctrl});
    rd(6'h3C, q);
    chk("unmapped read", 32'h0, q);
  endtask
  task automatic t_enable();
    logic [31:0] q;
    host.xfer(OFS_CMD_B, 1'b0, 32'h04, 4'hE, q);
    chkst("lane-less write", 9, 1'b0);
    wr(OFS_CMD_A, 8'h05);
    rd(OFS_STAT, q);
    chk("A enabled flags", 32'hF, {28'h0, q[3:0]});
    chk("A run levels", 32'h3, {30'h0, ctrl[0].rxRun, ctrl[0].txRun});
    chk("hunt pulse", 32'h1, {24'h0, huntC});
    wr(OFS_CMD_B, 8'h04);
    chkst("B tx enabled", 9, 1'b1);
  endtask
  task automatic t_both();
    logic [31:0] q;
    wr(OFS_CMD_A, 8'h0F);
    rd(OFS_STAT, q);
    chk("enable plus disable", 32'h0, {28'h0, q[3:0]});
    chk("run after disable", 32'h0, {30'h0, ctrl[0].rxRun, ctrl[0].txRun});
    evt[0].multidrop <= 1'b1;
    repeat (2) @(posedge clk);
    chk("multidrop keeps rx", 32'h1, {31'h0, ctrl[0].rxRun});
    evt[0].multidrop <= 1'b0;
  endtask
  task automatic t_misc();
    logic [7:0] m0, r0, t0;
    wr(OFS_CMD_A, 8'h01);
    for (int c = 0; c < 4; c++) begin
      m0 = mrC;
      r0 = rxC;
      t0 = txC;
      wr(OFS_CMD_A, 8'(c << 4));
      repeat (2) @(posedge clk);
      chk("misc pulses", {29'h0, c == 1, c == 2, c == 3}, {29'h0, mrC != m0, rxC != r0, txC != t0});
    end
    chkst("rx off after reset", 0, 1'b0);
  endtask
  task automatic t_err();
    logic [31:0] q;
    wr(OFS_CMD_A, 8'h01);
    @(posedge clk);
    evt[0].fifoFull <= 1'b1;
    evt[0].shiftHeld <= 1'b1;
    evt[0].rxChar <= 1'b1;
    @(posedge clk);
    evt[0].rxChar <= 1'b0;
    evt[0].frameErr <= 1'b1;
    evt[0].brkChange <= 1'b1;
    @(posedge clk);
    evt[0] <= '{txLine: 1'b1, default: 1'b0};
    rd(OFS_STAT, q);
    chk("overrun and change", 32'h7, {29'h0, q[16], q[6], q[4]});
    wr(OFS_CMD_A, 8'h40);
    rd(OFS_STAT, q);
    chk("error clear", 32'h4, {29'h0, q[16], q[6], q[4]});
    wr(OFS_CMD_A, 8'h50);
    rd(OFS_STAT, q);
    chk("change clear", 32'h0, {29'h0, q[16], q[6], q[4]});
  endtask
  task automatic t_clk(input logic [7:0] ca, input logic [7:0] cb, input logic [4:0] m,
                       input logic [3:0] et, input logic [3:0] e1);
    logic [15:0] s [4];
    logic [3:0]  d;
    wr(OFS_CSEL_A, ca);
    wr(OFS_CSEL_B, cb);
    // Let ticks from the old codes land before the snapshot
    repeat (2) @(posedge clk);
    s = tc;
    pulse(m);
    for (int i = 0; i < 4; i++) d[i] = (tc[i] != s[i]);
    chk("tick source", {28'h0, et}, {28'h0, d});
    chk("1x select", {28'h0, e1}, {28'h0, clkIs1x});
  endtask
  task automatic t_rate(input logic [7:0] aux, input int lo, input int hi);
    logic [15:0] s;
    int          d;
    wr(OFS_AUX, aux);
    wr(OFS_CSEL_A, 8'hCC);
    repeat (200) @(posedge clk);
    s = tc[0];
    repeat (10000) @(posedge clk);
    d = int'(tc[0] - s);
    chk("16x ticks per ms in range", 32'h1, {31'h0, d >= lo && d <= hi});
    chkst("set select bit", 25, aux[7]);
  endtask
  task automatic t_speed();
    logic [31:0] q;
    rd(OFS_SPEED, q);
    chkst("speed toggled on", 24, 1'b1);
    t_rate(8'h80, 612, 617);
    rd(OFS_SPEED, q);
    chkst("speed toggled off", 24, 1'b0);
  endtask
  task automatic t_break();
    wr(OFS_CSEL_A, 8'h0F);
    wr(OFS_CMD_A, 8'h60);
    pulse(5'h01);
    pulse(5'h01);
    chk("break refused", 32'h1, {31'h0, ctrl[0].serialOut});
    wr(OFS_CMD_A, 8'h04);
    wr(OFS_CMD_A, 8'h60);
    pulse(5'h01);
    chk("break on", 32'h0, {31'h0, ctrl[0].serialOut});
    chk("hold in break", 32'h1, {31'h0, ctrl[0].txHold});
    chk("B line idle", 32'h1, {31'h0, ctrl[1].serialOut});
    wr(OFS_CMD_A, 8'h70);
    repeat (2) @(posedge clk);
    chk("break off", 32'h1, {31'h0, ctrl[0].serialOut});
    chk("hold in mark", 32'h1, {31'h0, ctrl[0].txHold});
  endtask

  ////////////////////////////////////////////////////////////////
  // Watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    close_out();
  end
  initial begin
    sysRst = 1'b1;
    pins = 5'h00;
    // Idle transmit shifters mark the line
    evt[0] = '{txLine: 1'b1, default: 1'b0};
    evt[1] = evt[0];
    error_cnt = 0;
    n_tests = 0;
    repeat (4) @(posedge clk);
    sysRst <= 1'b0;
    t_reset();
    t_enable();
    t_both();
    t_misc();
    t_err();
    t_clk(8'hEF, 8'hFE, 5'h0F, 4'hF, 4'h6);
    t_clk(8'hFE, 8'hEF, 5'h02, 4'h1, 4'h9);
    t_clk(8'hDE, 8'hEE, 5'h10, 4'h1, 4'h0);
    t_clk(8'hEE, 8'hEE, 5'h04, 4'h8, 4'h0);
    t_rate(8'h00, 612, 617);
    t_rate(8'h80, 305, 309);
    t_speed();
    t_break();
    close_out();
  end
endmodule
`default_nettype wire
